// ===== dv/test_timer16_control_waveform.sv
// Self-checking bench for the 16-bit timer control block.
// Assumes the block is the only AHB-Lite slave, so hready is hreadyout.
`timescale 1ns/10ps
`default_nettype none
module test_timer16_control_waveform import timer16_ctrl_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hready, update_cond;
	logic dir_hw_load, dir_hw_value, hreadyout, hresp, count_tick;
	logic timer_enable, split_mode, direction, lock_update, buffer_transfer;
	logic restart_pulse, hard_reset_pulse, top_is_compare0, update_at_top;
	logic update_at_bottom, ovf_at_top, ovf_at_bottom, mode_reserved;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, cmp_buf_write, wave_level, buffer_valid;
	logic [2:0] pin_override, pin_level, logic_block_out;
	int err_total, checked;
	logic [31:0] seed = 32'h0000_5648; // Start value 22088
	// Mode decode table per code: bit n is the value for mode n
	logic [7:0] m_res = 8'h14, m_cmp0 = 8'h02, m_utop = 8'h03;
	logic [7:0] m_ubot = 8'hE8, m_otop = 8'h63, m_obot = 8'hC8;
	int div_m [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
	int reg_m [4];

	assign hready = hreadyout;

	timer16_control_waveform timer16_control_waveform_inst (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .update_cond, .cmp_buf_write,
		.dir_hw_load, .dir_hw_value, .wave_level, .count_tick,
		.timer_enable, .split_mode, .direction, .lock_update, .buffer_valid,
		.buffer_transfer, .restart_pulse, .hard_reset_pulse,
		.top_is_compare0, .update_at_top, .update_at_bottom, .ovf_at_top,
		.ovf_at_bottom, .mode_reserved, .pin_override, .pin_level,
		.logic_block_out);

	// Free-running 125 MHz clock
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	// Bounded wait so a stuck slave ends the run instead of hanging it
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) begin
			$display("[ERR] hready expected 1 seen stuck low");
			err_total++;
			results();
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		wait_rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		ahb(1'b1, {24'h00_0000, idx, 2'b00}, d, r);
		#1;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] r;
		ahb(1'b0, {24'h00_0000, idx, 2'b00}, 8'h00, r);
		chk("read data", {24'h00_0000, e}, r);
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	// One-cycle datapath strobes, answered one cycle later
	task automatic strobe(input logic u, input logic [2:0] b,
		input logic l);
		@(posedge hclk);
		update_cond <= u;
		cmp_buf_write <= b;
		dir_hw_load <= l;
		dir_hw_value <= l;
		@(posedge hclk);
		update_cond <= 1'b0;
		cmp_buf_write <= 3'h0;
		dir_hw_load <= 1'b0;
		#1;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (count_tick !== 1'b1 && n < 1100);
		if (n >= 1100) begin
			$display("[ERR] count_tick expected 1 seen none");
			err_total++;
			results();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int i, n;
		logic [31:0] v, r;
		{hsel, hwrite, update_cond, dir_hw_load, dir_hw_value} = 5'h00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'b00;
		hsize = 3'h2;
		cmp_buf_write = 3'h0;
		wave_level = 3'h0;
		hresetn = 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk("enable", 32'h0, 32'(timer_enable));
		chk("lock", 32'h0, 32'(lock_update));
		for (i = 0; i < 6; i++) rd(i[5:0], 8'h00);
		ahb(1'b1, 32'h0000_0100, 8'hFF, r);
		ahb(1'b0, 32'h0000_0100, 8'h00, r);
		chk("unmapped", 32'h0, r);
		$display("test reset done");
		for (i = 0; i < 16; i++) begin
			v = rnd() & {24'h00_0000, (i % 4 == 0) ? 8'h0F : (i % 4 == 1) ?
				8'h7F : (i % 4 == 2) ? 8'h07 : 8'h01};
			reg_m[i % 4] = int'(v);
			wr(i[5:0] & 6'h03, v[7:0]);
			rd(i[5:0] & 6'h03, 8'(reg_m[i % 4]));
			chk("enable", 32'(reg_m[0] & 1), 32'(timer_enable));
			chk("split", 32'(reg_m[3] & 1), 32'(split_mode));
		end
		for (i = 0; i < 4; i++) wr(i[5:0], 8'h00);
		wr(IDX_COMMAND_DIRECTION_CLEAR, 8'h03);
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			wr(IDX_WAVEFORM_CONTROL, i[7:0]);
			step(1);
			chk("reserved", 32'(m_res[i]), 32'(mode_reserved));
			// Reserved codes must raise no event decode at all
			chk("top cmp0", 32'(m_cmp0[i]), 32'(top_is_compare0));
			chk("upd top", 32'(m_utop[i]), 32'(update_at_top));
			chk("upd bot", 32'(m_ubot[i]), 32'(update_at_bottom));
			chk("ovf top", 32'(m_otop[i]), 32'(ovf_at_top));
			chk("ovf bot", 32'(m_obot[i]), 32'(ovf_at_bottom));
		end
		$display("test modes done");
		for (i = 0; i < 8; i++) begin
			wr(IDX_CLOCK_ENABLE_CONTROL, {4'h0, i[2:0], 1'b1});
			// First tick may be from the old select, second from a
			// divider count left mid-way; only the third gap is clean
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			chk("tick period", 32'(div_m[i]), 32'(n));
		end
		wr(IDX_CLOCK_ENABLE_CONTROL, 8'h00);
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge hclk);
			if (count_tick === 1'b1) n++;
		end
		chk("ticks while off", 32'h0, 32'(n));
		$display("test prescaler done");
		// Channels 0 and 2 enabled, single-slope, forced value 110
		wr(IDX_WAVEFORM_CONTROL, 8'h53);
		wr(IDX_OUTPUT_VALUE_CONTROL, 8'h06);
		step(2);
		chk("override off", 32'h5, 32'(pin_override));
		chk("forced level", 32'h6, 32'(pin_level));
		chk("logic block", 32'h6, 32'(logic_block_out));
		v = rnd();
		@(posedge hclk);
		wave_level <= v[2:0];
		wr(IDX_CLOCK_ENABLE_CONTROL, 8'h01);
		step(2);
		chk("override on", 32'h5, 32'(pin_override));
		chk("wave level", 32'(v[2:0]), 32'(pin_level));
		wr(IDX_WAVEFORM_CONTROL, 8'h50);
		step(2);
		chk("normal override", 32'h0, 32'(pin_override));
		wr(IDX_CLOCK_ENABLE_CONTROL, 8'h00);
		$display("test pins done");
		// Auto-lock with channels 0 and 1 enabled
		wr(IDX_WAVEFORM_CONTROL, 8'h3B);
		step(2);
		chk("lock armed", 32'h1, 32'(lock_update));
		strobe(1'b0, 3'b001, 1'b0);
		step(2);
		chk("lock partial", 32'h1, 32'(lock_update));
		chk("valid", 32'h1, 32'(buffer_valid));
		strobe(1'b0, 3'b010, 1'b0);
		step(2);
		chk("lock released", 32'h0, 32'(lock_update));
		rd(IDX_BUFFER_STATUS, 8'h03);
		strobe(1'b1, 3'b000, 1'b0);
		chk("transfer", 32'h1, 32'(buffer_transfer));
		step(2);
		chk("lock again", 32'h1, 32'(lock_update));
		chk("valid clear", 32'h0, 32'(buffer_valid));
		strobe(1'b1, 3'b000, 1'b0);
		chk("locked transfer", 32'h0, 32'(buffer_transfer));
		wr(IDX_COMMAND_DIRECTION_SET, 8'h04);
		chk("forced transfer", 32'h1, 32'(buffer_transfer));
		rd(IDX_COMMAND_DIRECTION_SET, 8'h02);
		wr(IDX_WAVEFORM_CONTROL, 8'h33);
		wr(IDX_COMMAND_DIRECTION_CLEAR, 8'h02);
		rd(IDX_COMMAND_DIRECTION_CLEAR, 8'h00);
		strobe(1'b1, 3'b000, 1'b0);
		chk("open transfer", 32'h1, 32'(buffer_transfer));
		wr(IDX_COMMAND_DIRECTION_SET, 8'h03);
		rd(IDX_COMMAND_DIRECTION_SET, 8'h03);
		wr(IDX_COMMAND_DIRECTION_CLEAR, 8'h01);
		rd(IDX_COMMAND_DIRECTION_CLEAR, 8'h02);
		strobe(1'b0, 3'b000, 1'b1);
		chk("hw direction", 32'h1, 32'(direction));
		$display("test lock done");
		wr(IDX_COMMAND_DIRECTION_SET, 8'h08);
		chk("restart", 32'h1, 32'(restart_pulse));
		step(1);
		chk("restart dir", 32'h0, 32'(direction));
		rd(IDX_WAVEFORM_CONTROL, 8'h33);
		wr(IDX_CLOCK_ENABLE_CONTROL, 8'h01);
		wr(IDX_COMMAND_DIRECTION_SET, 8'h0C);
		chk("reset ignored", 32'h0, 32'(hard_reset_pulse));
		wr(IDX_CLOCK_ENABLE_CONTROL, 8'h00);
		wr(IDX_COMMAND_DIRECTION_CLEAR, 8'h0C);
		chk("hard reset", 32'h1, 32'(hard_reset_pulse));
		rd(IDX_WAVEFORM_CONTROL, 8'h00);
		rd(IDX_COMMAND_DIRECTION_SET, 8'h00);
		$display("test commands done");
		results();
	end
endmodule
`default_nettype wire

// ===== rtl/timer16_control_waveform.sv
// Control section of the 16-bit timer: clock select, waveform mode,
// output overrides, command strobes, lock update and direction.
// Assumes an AHB-Lite master on one hclk domain and a counter datapath
// elsewhere that supplies update_cond, buffer writes and wave levels.
//
// Contract
// - count tick divides hclk by 1,2,4,8,16,64,256,1024 per select code.
// - timer runs only while the enable bit is one.
// - compare output enable lets the waveform override the port pin.
// - auto-lock holds lock-update set until enabled buffers are valid.
// - after auto-clear, lock-update returns to one at next transfer.
// - mode 0 normal, mode 1 frequency, top events when counting up.
// - modes 3 and 7 update and overflow at bottom.
// - dual-slope updates at bottom; mode 5 top, mode 6 both overflow.
// - normal mode drives no waveform; others need compare output enable.
// - while disabled, output value bits set the waveform level.
// - forced value reaches pad only when enabled; logic block bypasses.
// - split-mode bit turns the timer into two 8-bit timers.
// - clear strobe clears each lock/direction bit written as one.
// - set strobe sets each lock/direction bit written as one.
// - command field: 1 forces update, 2 restart; reads back zero.
// - command 3 hard-resets only while the timer is disabled.
// - lock-update blocks condition transfers, never commanded updates.
// - direction bit: zero counts up, one counts down.
// - buffer-valid bits set on buffer write, clear on transfer.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module timer16_control_waveform
	import timer16_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic update_cond,
	input wire logic [2:0] cmp_buf_write,
	input wire logic dir_hw_load,
	input wire logic dir_hw_value,
	input wire logic [2:0] wave_level,
	output logic count_tick,
	output logic timer_enable,
	output logic split_mode,
	output logic direction,
	output logic lock_update,
	output logic [2:0] buffer_valid,
	output logic buffer_transfer,
	output logic restart_pulse,
	output logic hard_reset_pulse,
	output logic top_is_compare0,
	output logic update_at_top,
	output logic update_at_bottom,
	output logic ovf_at_top,
	output logic ovf_at_bottom,
	output logic mode_reserved,
	output logic [2:0] pin_override,
	output logic [2:0] pin_level,
	output logic [2:0] logic_block_out
);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	bus_state_e state_r;
	logic [5:0] idx_r;
	logic hit_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic addr_phase;
	logic wr_en;
	logic [7:0] wdata;
	logic [7:0] rd_value;

	assign addr_phase = hsel && hready && htrans[1];
	assign wr_en = (state_r == BUS_WRITE) && hit_r;
	assign wdata = hwdata[7:0];

	// Writes are zero-wait; reads take one wait state so read data
	// comes from a flop and sees a write made just before it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= BUS_IDLE;
			idx_r <= '0;
			hit_r <= 1'b0;
			hreadyout_r <= 1'b1;
		end else begin
			unique case (state_r)
				BUS_IDLE, BUS_WRITE: begin
					if (addr_phase) begin
						state_r <= hwrite ? BUS_WRITE : BUS_READ;
						idx_r <= haddr[7:2];
						hit_r <= (haddr[31:8] == 24'h00_0000);
						hreadyout_r <= hwrite;
					end else begin
						state_r <= BUS_IDLE;
					end
				end
				BUS_READ: begin
					state_r <= BUS_IDLE;
					hreadyout_r <= 1'b1;
				end
			endcase
		end
	end

	// Read data latched at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= '0;
		end else if (state_r == BUS_READ) begin
			hrdata_r <= {24'h00_0000, hit_r ? rd_value : 8'h00};
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic enable_r;
	logic [2:0] presc_sel_r;
	logic [2:0] cmp_en_r;
	logic auto_lock_r;
	logic [2:0] wave_mode_r;
	logic [2:0] cmp_ov_r;
	logic split_r;
	logic lock_update_bit_r;
	logic lock_update_bit_nxt;
	logic dir_r;
	logic auto_lock_update_seen_r;
	logic [2:0] bv_r;
	logic wr_e_clr;
	logic wr_e_set;
	logic wr_e_any;
	logic [1:0] cmd_code;
	logic cmd_update;
	logic cmd_restart;
	logic cmd_hard_reset;
	logic transfer_now;
	logic all_valid;

	assign wr_e_clr = wr_en && (idx_r == IDX_COMMAND_DIRECTION_CLEAR);
	assign wr_e_set = wr_en && (idx_r == IDX_COMMAND_DIRECTION_SET);
	assign wr_e_any = wr_e_clr || wr_e_set;
	assign cmd_code = wdata[CMD_LSB +: 2];
	// Commands act on write through either strobe register
	assign cmd_update = wr_e_any && (cmd_code == CMD_UPDATE);
	assign cmd_restart = wr_e_any && (cmd_code == CMD_RESTART);
	// Hard reset is dropped while running, with no bus error
	assign cmd_hard_reset = wr_e_any && (cmd_code == CMD_HARD_RESET)
		&& !enable_r;
	// Lock blocks condition transfers only, never the command
	assign transfer_now = (update_cond && !lock_update_bit_r) || cmd_update;
	assign all_valid = &(bv_r | ~cmp_en_r);

	// Clock select and enable; cleared by a hard reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_r <= CTRL_RESET[ENABLE_BIT];
			presc_sel_r <= CTRL_RESET[PRESC_LSB +: 3];
		end else if (cmd_hard_reset) begin
			enable_r <= 1'b0;
			presc_sel_r <= '0;
		end else if (wr_en && idx_r == IDX_CLOCK_ENABLE_CONTROL) begin
			enable_r <= wdata[ENABLE_BIT];
			presc_sel_r <= wdata[PRESC_LSB +: 3];
		end
	end

	// Waveform control, output values and split mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_en_r <= CTRL_RESET[CMP_EN_LSB +: 3];
			auto_lock_r <= CTRL_RESET[AUTO_LOCK_BIT];
			wave_mode_r <= CTRL_RESET[MODE_LSB +: 3];
			cmp_ov_r <= CTRL_RESET[OV_LSB +: 3];
			split_r <= CTRL_RESET[SPLIT_BIT];
		end else if (cmd_hard_reset) begin
			cmp_en_r <= '0;
			auto_lock_r <= 1'b0;
			wave_mode_r <= '0;
			cmp_ov_r <= '0;
			split_r <= 1'b0;
		end else if (wr_en) begin
			if (idx_r == IDX_WAVEFORM_CONTROL) begin
				cmp_en_r <= wdata[CMP_EN_LSB +: 3];
				auto_lock_r <= wdata[AUTO_LOCK_BIT];
				wave_mode_r <= wdata[MODE_LSB +: 3];
			end
			if (idx_r == IDX_OUTPUT_VALUE_CONTROL) begin
				cmp_ov_r <= wdata[OV_LSB +: 3];
			end
			if (idx_r == IDX_SPLIT_MODE_CONTROL) begin
				split_r <= wdata[SPLIT_BIT];
			end
		end
	end

	// Lock update: hardware set wins over a software clear
	always_comb begin
		lock_update_bit_nxt = lock_update_bit_r;
		if (auto_lock_r && all_valid) begin
			lock_update_bit_nxt = 1'b0;
		end
		if (wr_e_clr && wdata[LOCK_UPDATE_BIT_BIT]) begin
			lock_update_bit_nxt = 1'b0;
		end
		if (wr_e_set && wdata[LOCK_UPDATE_BIT_BIT]) begin
			lock_update_bit_nxt = 1'b1;
		end
		if (auto_lock_r && (!auto_lock_update_seen_r || transfer_now)) begin
			lock_update_bit_nxt = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_update_bit_r <= 1'b0;
			auto_lock_update_seen_r <= 1'b0;
		end else if (cmd_hard_reset) begin
			lock_update_bit_r <= 1'b0;
			auto_lock_update_seen_r <= 1'b0;
		end else begin
			lock_update_bit_r <= lock_update_bit_nxt;
			auto_lock_update_seen_r <= auto_lock_r;
		end
	end

	// Direction: hardware load, then software strobes, restart last
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_r <= 1'b0;
		end else if (cmd_hard_reset || cmd_restart) begin
			dir_r <= 1'b0;
		end else if (wr_e_clr && wdata[DIR_BIT]) begin
			dir_r <= 1'b0;
		end else if (wr_e_set && wdata[DIR_BIT]) begin
			dir_r <= 1'b1;
		end else if (dir_hw_load) begin
			dir_r <= dir_hw_value;
		end
	end

	// ------------------------------------------------------------
	// Per-channel buffer-valid flags and output steering
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			// A buffer write in the transfer cycle keeps its flag
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					bv_r[ch] <= 1'b0;
				end else if (cmp_buf_write[ch]) begin
					bv_r[ch] <= 1'b1;
				end else if (transfer_now || cmd_hard_reset) begin
					bv_r[ch] <= 1'b0;
				end
			end

			// Stopped timer shows the software value bit
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_level[ch] <= 1'b0;
					pin_override[ch] <= 1'b0;
					logic_block_out[ch] <= 1'b0;
				end else begin
					pin_level[ch] <= enable_r ? wave_level[ch]
						: cmp_ov_r[ch];
					pin_override[ch] <= cmp_en_r[ch]
						&& (wave_mode_r != WAVE_NORMAL || !enable_r);
					logic_block_out[ch] <= enable_r ? wave_level[ch]
						: cmp_ov_r[ch];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Mode decode and event outputs
	// ------------------------------------------------------------
	logic top_events;
	assign top_events = (wave_mode_r == WAVE_NORMAL)
		|| (wave_mode_r == WAVE_FREQUENCY);

	// Top events only apply while counting up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			top_is_compare0 <= 1'b0;
			update_at_top <= 1'b0;
			update_at_bottom <= 1'b0;
			ovf_at_top <= 1'b0;
			ovf_at_bottom <= 1'b0;
			mode_reserved <= 1'b0;
		end else begin
			top_is_compare0 <= (wave_mode_r == WAVE_FREQUENCY);
			update_at_top <= top_events && !dir_r;
			update_at_bottom <= (wave_mode_r == WAVE_SINGLE_SLOPE)
				|| (wave_mode_r[2]
				&& wave_mode_r != WAVE_RESERVED_B);
			ovf_at_top <= (top_events && !dir_r)
				|| (wave_mode_r == WAVE_DUAL_TOP)
				|| (wave_mode_r == WAVE_DUAL_BOTH);
			ovf_at_bottom <= (wave_mode_r == WAVE_SINGLE_SLOPE)
				|| (wave_mode_r == WAVE_DUAL_BOTH)
				|| (wave_mode_r == WAVE_DUAL_BOTTOM);
			mode_reserved <= (wave_mode_r == WAVE_RESERVED_A)
				|| (wave_mode_r == WAVE_RESERVED_B);
		end
	end

	// Command and transfer pulses to the datapath
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buffer_transfer <= 1'b0;
			restart_pulse <= 1'b0;
			hard_reset_pulse <= 1'b0;
		end else begin
			buffer_transfer <= transfer_now;
			restart_pulse <= cmd_restart;
			hard_reset_pulse <= cmd_hard_reset;
		end
	end

	// Count-clock divider, stopped while disabled
	timer16_prescaler u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(enable_r),
		.restart(cmd_restart || cmd_hard_reset),
		.presc_sel(presc_sel_r),
		.tick(count_tick)
	);

	assign timer_enable = enable_r;
	assign split_mode = split_r;
	assign direction = dir_r;
	assign lock_update = lock_update_bit_r;
	assign buffer_valid = bv_r;

	// Read mux; command field always reads zero
	always_comb begin
		unique case (idx_r)
			IDX_CLOCK_ENABLE_CONTROL: rd_value = {4'h0, presc_sel_r, enable_r};
			IDX_WAVEFORM_CONTROL:
				rd_value = {1'b0, cmp_en_r, auto_lock_r, wave_mode_r};
			IDX_OUTPUT_VALUE_CONTROL: rd_value = {5'h00, cmp_ov_r};
			IDX_SPLIT_MODE_CONTROL: rd_value = {7'h00, split_r};
			IDX_COMMAND_DIRECTION_CLEAR, IDX_COMMAND_DIRECTION_SET:
				rd_value = {6'h00, lock_update_bit_r, dir_r};
			IDX_BUFFER_STATUS: rd_value = {5'h00, bv_r};
			default: rd_value = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_relock_cause;
		auto_lock_r && auto_lock_update_seen_r && transfer_now && !cmd_hard_reset;
	endsequence

	a_run_gating: assert property (!enable_r |=> !count_tick)
		else $error("count tick while disabled");
	a_div1_every: assert property (
		enable_r && presc_sel_r == 3'h0 && !cmd_restart |=> count_tick)
		else $error("undivided clock missed a tick");
	a_div_spacing: assert property (count_tick && presc_sel_r != 3'h0
		&& presc_sel_r == $past(presc_sel_r) |=> !count_tick)
		else $error("divided ticks back to back");
	a_transfer_cause: assert property (buffer_transfer |->
		$past(cmd_update) || ($past(update_cond) && !$past(lock_update_bit_r)))
		else $error("transfer without cause");
	a_lock_blocks: assert property (
		update_cond && lock_update_bit_r && !cmd_update |=> !buffer_transfer)
		else $error("locked condition transferred");
	a_autolock_clear: assert property (auto_lock_r && auto_lock_update_seen_r
		&& all_valid && !transfer_now && !wr_e_set |=> !lock_update_bit_r)
		else $error("auto-lock did not release");
	a_autolock_relock: assert property (s_relock_cause |=> lock_update_bit_r)
		else $error("auto-lock did not relock");
	a_valid_clear: assert property (transfer_now
		&& cmp_buf_write == 3'b000 |=> buffer_valid == 3'b000)
		else $error("buffer valid survived transfer");
	a_hard_reset_gate: assert property (
		hard_reset_pulse |-> !$past(enable_r))
		else $error("hard reset while enabled");
	a_cmd_reads_zero: assert property (state_r == BUS_READ
		&& (idx_r == IDX_COMMAND_DIRECTION_SET) |=> hrdata[3:2] == 2'b00)
		else $error("command field read nonzero");
	a_idle_level: assert property (
		!enable_r |=> pin_level == $past(cmp_ov_r))
		else $error("stopped level not from value bits");
	a_normal_no_wave: assert property (
		enable_r && wave_mode_r == 3'h0 |=> pin_override == 3'b000)
		else $error("normal mode overrides a pin");

endmodule
`default_nettype wire

// ===== rtl/timer16_ctrl_pkg.sv
// Constants shared by the 16-bit timer control block and its prescaler.
// Assumes a single peripheral clock; no other package is needed.
package timer16_ctrl_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CLOCK_ENABLE_CONTROL = 6'h00;
	localparam logic [5:0] IDX_WAVEFORM_CONTROL = 6'h01;
	localparam logic [5:0] IDX_OUTPUT_VALUE_CONTROL = 6'h02;
	localparam logic [5:0] IDX_SPLIT_MODE_CONTROL = 6'h03;
	localparam logic [5:0] IDX_COMMAND_DIRECTION_CLEAR = 6'h04;
	localparam logic [5:0] IDX_COMMAND_DIRECTION_SET = 6'h05;
	localparam logic [5:0] IDX_BUFFER_STATUS = 6'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT = 0;
	localparam int PRESC_LSB = 1;
	localparam int MODE_LSB = 0;
	localparam int AUTO_LOCK_BIT = 3;
	localparam int CMP_EN_LSB = 4;
	localparam int OV_LSB = 0;
	localparam int SPLIT_BIT = 0;
	localparam int CMD_LSB = 2;
	localparam int LOCK_UPDATE_BIT_BIT = 1;
	localparam int DIR_BIT = 0;
	localparam int CHANNELS = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ------------------------------------------------------------
	// Commands, modes, prescaler, bus states
	// ------------------------------------------------------------
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_UPDATE = 2'h1;
	localparam logic [1:0] CMD_RESTART = 2'h2;
	localparam logic [1:0] CMD_HARD_RESET = 2'h3;

	typedef enum logic [2:0] {
		WAVE_NORMAL = 3'h0,
		WAVE_FREQUENCY = 3'h1,
		WAVE_SINGLE_SLOPE = 3'h3,
		WAVE_DUAL_TOP = 3'h5,
		WAVE_DUAL_BOTH = 3'h6,
		WAVE_DUAL_BOTTOM = 3'h7
	} waveform_mode_e;
	localparam logic [2:0] WAVE_RESERVED_A = 3'h2;
	localparam logic [2:0] WAVE_RESERVED_B = 3'h4;

	localparam int PRESC_WIDTH = 10;
	// log2 of the division for select codes 0..7: 1,2,4,8,16,64,256,1024
	localparam logic [3:0] PRESC_SHIFT [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
		4'h4, 4'h6, 4'h8, 4'hA};

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10
	} bus_state_e;

endpackage

// ===== rtl/timer16_prescaler.sv
// Count-clock enable generator: one-cycle tick at the selected division.
// Assumes run, restart and select are synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module timer16_prescaler
	import timer16_ctrl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic restart,
	input wire logic [2:0] presc_sel,
	output logic tick
);

	logic [PRESC_WIDTH-1:0] cnt_r;
	logic [PRESC_WIDTH-1:0] mask;
	logic [3:0] shift;
	logic tick_r;

	// ------------------------------------------------------------
	// Mask of low counter bits that must all be one
	// ------------------------------------------------------------
	assign shift = PRESC_SHIFT[presc_sel];
	genvar gi;
	generate
		for (gi = 0; gi < PRESC_WIDTH; gi++) begin : g_mask
			assign mask[gi] = (4'(gi) < shift);
		end
	endgenerate

	// Free-running divider; held at zero while stopped so that
	// the first tick after enable comes a full period later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
		end else if (!run || restart) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Tick when the selected low bits are all ones
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= run && !restart && ((cnt_r & mask) == mask);
		end
	end

	assign tick = tick_r;

endmodule
`default_nettype wire
